// *** core/read_wrap_training.v ***
// Purpose: read output side of an octal serial flash: wrap sequencing,
//   training pattern lanes and dummy cycle wait, driven by the link clock
// Assumes: apb slave on clk_sys; link clock sclk and select csn are pins
// Notes: one data item per sclk rising edge; ddr is outside this block
// How it works
// R1: wrapped reads walk to the end of the aligned 16/32/64 byte block and restart at its start.
// R2: with the switching select bit set, all eight lanes carry the same training bit.
// R3: with the switching select bit clear, lane three carries the inverted training bit.
// R4: the training byte lives in configuration index 0ah and software may rewrite it.
// R5: the training byte goes out msb first, bit 7 down to bit 0.
// R6: after reset the training byte is 55h with no inverted lane.
// R7: the host must pick enough dummy cycles; octal ddr below 3 is not allowed.
// R8: wrap byte ffh is continuous, feh/fdh/fch give 64/32/16 byte wrap.
// R9: dummy byte 01h..1eh gives that many cycles, 00h and 1fh the default.
// R10: a training read waits two more dummy cycles than the configured count.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "read_wrap_consts.vh"
module read_wrap_training #(
  parameter ADDR_W = 23
) (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sclk,
  input wire csn,
  output reg [7:0] dataOut,
  output reg dataOe,
  output reg [ADDR_W-1:0] memAddr,
  input wire [7:0] memData
);
  // configuration bytes
  reg [7:0] dummyCfg_q;
  reg [7:0] wrapCfg_q;
  reg [7:0] trainPat_q;
  reg [7:0] swSel_q;
  reg [1:0] cmd_q;
  reg [ADDR_W-1:0] startAddr_q;
  reg lowDummy_q;
  // link sampling, two stages before use
  reg sclkS1_q, sclkS2_q, sclkS3_q;
  reg csnS1_q, csnS2_q;
  // sequencer
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DATA = 3'b100;
  reg [2:0] state_q;
  // six bits: 30 dummies plus the two training extras makes 32,
  // which a five bit counter would silently wrap to zero
  reg [5:0] waitCnt_q;
  reg [2:0] bitIdx_q;
  reg [ADDR_W-1:0] addr_q;

  wire [9:0] regIdx = paddr[11:2];
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sclkRise = sclkS2_q && !sclkS3_q;
  wire active = !csnS2_q;

  // effective dummy count, reserved codes fall back to default
  function [4:0] dummyCount;
    input [7:0] cfg;
    begin
      if (cfg == 8'h00 || cfg > `DUMMY_MAX)
        dummyCount = `DUMMY_DEF; // see R9
      else
        dummyCount = cfg[4:0]; // see R9
    end
  endfunction

  // next address within the wrap block; reserved codes read continuous
  function [ADDR_W-1:0] nextAddr;
    input [ADDR_W-1:0] a;
    input [7:0] cfg;
    reg [ADDR_W-1:0] inc;
    begin
      inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
      case (cfg)
        `WRAP_64: nextAddr = {a[ADDR_W-1:6], inc[5:0]}; // see R1, R8
        `WRAP_32: nextAddr = {a[ADDR_W-1:5], inc[4:0]}; // see R1, R8
        `WRAP_16: nextAddr = {a[ADDR_W-1:4], inc[3:0]}; // see R1, R8
        default: nextAddr = inc; // see R8
      endcase
    end
  endfunction

  // zero wait states; unmapped index gives pslverr
  // refused writes leave every register untouched
  assign pready = 1'b1;
  assign pslverr = acc && !(regIdx == `IDX_DUMMY || regIdx == `IDX_WRAP ||
    regIdx == `IDX_TRAIN || regIdx == `IDX_SWSEL || regIdx == `IDX_CMD ||
    regIdx == `IDX_STAT || regIdx == `IDX_START);

  // register writes
  always @(posedge clk_sys) begin
    if (!rstn) begin
      dummyCfg_q <= `DUMMY_RST;
      wrapCfg_q <= `WRAP_CONT;
      trainPat_q <= `TRAIN_RST; // see R6
      swSel_q <= `SWSEL_RST; // see R6
      cmd_q <= 2'd0;
      startAddr_q <= {ADDR_W{1'b0}};
    end else if (wr) begin
      case (regIdx)
        `IDX_DUMMY: dummyCfg_q <= pwdata[7:0];
        `IDX_WRAP: wrapCfg_q <= pwdata[7:0];
        `IDX_TRAIN: trainPat_q <= pwdata[7:0]; // see R4
        `IDX_SWSEL: swSel_q <= pwdata[7:0];
        `IDX_CMD: cmd_q <= pwdata[1:0];
        `IDX_START: startAddr_q <= pwdata[ADDR_W-1:0];
        default: cmd_q <= cmd_q;
      endcase
    end
  end

  // read mux; status shows state, too-few-dummy flag, current address
  always @* begin
    prdata = 32'h00000000;
    case (regIdx)
      `IDX_DUMMY: prdata[7:0] = dummyCfg_q;
      `IDX_WRAP: prdata[7:0] = wrapCfg_q;
      `IDX_TRAIN: prdata[7:0] = trainPat_q;
      `IDX_SWSEL: prdata[7:0] = swSel_q;
      `IDX_CMD: prdata[1:0] = cmd_q;
      // warning on top, address in the middle, one-hot state at the bottom
      `IDX_STAT: prdata = {lowDummy_q, {(28-ADDR_W){1'b0}}, addr_q, state_q};
      `IDX_START: prdata[ADDR_W-1:0] = startAddr_q;
      default: prdata = 32'h00000000;
    endcase
  end

  // live warning: dummy count below the octal ddr minimum
  // recomputed every cycle so it follows the register, not sticky;
  // the device cannot refuse the setting, only report it
  always @(posedge clk_sys) begin
    if (!rstn)
      lowDummy_q <= 1'b0;
    else
      lowDummy_q <= dummyCount(dummyCfg_q) < `OCT_DDR_MIN; // see R7
  end

  // synchronise the link pins; third stage only for edge finding
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      csnS1_q <= 1'b1;
      csnS2_q <= 1'b1;
    end else begin
      sclkS1_q <= sclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      csnS1_q <= csn;
      csnS2_q <= csnS1_q;
    end
  end

  // sequencer: dummy wait, then one item per link clock rise
  always @(posedge clk_sys) begin
    if (!rstn || !active) begin
      state_q <= ST_IDLE;
      waitCnt_q <= 6'd0;
      bitIdx_q <= 3'd7;
      addr_q <= {ADDR_W{1'b0}};
      dataOe <= 1'b0;
      dataOut <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          addr_q <= startAddr_q;
          bitIdx_q <= 3'd7; // see R5
          if (cmd_q == `CMD_TRAIN)
            waitCnt_q <= {1'b0, dummyCount(dummyCfg_q)} + {1'b0, `TRAIN_EXTRA}; // see R10
          else
            waitCnt_q <= {1'b0, dummyCount(dummyCfg_q)}; // see R9
          if (cmd_q == `CMD_READ || cmd_q == `CMD_TRAIN)
            state_q <= ST_WAIT;
        end
        // count never starts at zero: the decoded dummy count is at least one
        ST_WAIT: begin
          if (sclkRise) begin
            waitCnt_q <= waitCnt_q - 6'd1;
            if (waitCnt_q == 6'd1)
              state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (sclkRise) begin
            dataOe <= 1'b1;
            if (cmd_q == `CMD_TRAIN) begin
              // msb first, same bit on every lane except lane three when the switching select bit is clear
              dataOut <= {8{trainPat_q[bitIdx_q]}}; // see R2, R5
              if (!swSel_q[`SWSEL_BIT])
                dataOut[3] <= ~trainPat_q[bitIdx_q]; // see R3
              bitIdx_q <= bitIdx_q - 3'd1;
            end else begin
              dataOut <= memData;
              addr_q <= nextAddr(addr_q, wrapCfg_q); // see R1
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // memory address follows the sequencer
  // one cycle behind addr_q, well inside one link clock period
  always @(posedge clk_sys) begin
    if (!rstn)
      memAddr <= {ADDR_W{1'b0}};
    else
      memAddr <= addr_q;
  end
endmodule // read_wrap_training

// *** shared/read_wrap_consts.vh ***
// Purpose: constants for the read wrap / training pattern block
// Assumes: apb byte addresses are four times the configuration index
// Notes: definitions only
`ifndef READ_WRAP_CONSTS_VH
`define READ_WRAP_CONSTS_VH
`define IDX_DUMMY 8'h01
`define IDX_WRAP 8'h07
`define IDX_TRAIN 8'h0a
`define IDX_SWSEL 8'h0b
`define IDX_CMD 8'h10
`define IDX_STAT 8'h11
`define IDX_START 8'h12
`define WRAP_CONT 8'hff
`define WRAP_64 8'hfe
`define WRAP_32 8'hfd
`define WRAP_16 8'hfc
`define TRAIN_RST 8'h55
`define SWSEL_RST 8'hff
`define SWSEL_BIT 6
`define DUMMY_RST 8'h1f
`define DUMMY_DEF 5'd18
`define DUMMY_MAX 8'h1e
`define TRAIN_EXTRA 5'd2
`define OCT_DDR_MIN 5'd3
`define CMD_READ 2'd1
`define CMD_TRAIN 2'd2
`endif

// *** verif/read_wrap_training_sva.sv ***
// Purpose: port checks for read_wrap_training
// Assumes: one clk_sys domain, rstn active low
// Notes: link pins pass two syncs, so bounds leave slack
`timescale 1ns/1ns
module read_wrap_training_sva (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire sclk,
  input wire csn,
  input wire [7:0] dataOut,
  input wire dataOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // apb answers and refusals
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_map; psel && paddr == 12'h028 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("pattern index refused");
  property p_bad; psel && penable && paddr == 12'h0f0 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped accepted");
  // lanes only driven inside a frame
  property p_idle; csn && $past(csn, 6) |-> !dataOe; endproperty
  a_idle: assert property (p_idle) else $error("driving while idle");
  property p_rise; $rose(dataOe) |-> !csn && !$past(csn, 3); endproperty
  a_rise: assert property (p_rise) else $error("drive without select");
  property p_clr; $rose(csn) |-> ##[1:6] !dataOe; endproperty
  a_clr: assert property (p_clr) else $error("lanes not released");
  // no link edge for six cycles means the driven lanes may not move
  property p_hold; $stable({sclk, csn})[*6] ##1 dataOe && $past(dataOe) |-> $stable(dataOut);
  endproperty
  a_hold: assert property (p_hold) else $error("lanes moved");
  c_oe: cover property ($rose(dataOe));
  c_inv: cover property (dataOe && dataOut == 8'h08);
  c_bad: cover property (pslverr);
endmodule // read_wrap_training_sva

// *** verif/host_model.sv ***
// Purpose: host side, drives link clock and select
// Assumes: one item per sclk rise, held until the next rise
// Notes: sclk stands low between frames
`timescale 1ns/1ns
module host_model (
  output reg sclk,
  output reg csn,
  input wire [7:0] dataOut
);
  reg [7:0] cap [0:63];
  initial {sclk, csn} = 2'b01;
  // sample late, the lanes settle a few system clocks after a rise
  task frame(input integer n);
    integer i;
    // step off the system clock edge before dropping select
    #10 csn = 1'b0;
    #400;
    for (i = 0; i < n; i = i + 1) begin
      #10 sclk = 1'b1;
      #200 sclk = 1'b0;
      #190 cap[i] = dataOut;
    end
    #10 csn = 1'b1;
    #800;
  endtask
endmodule // host_model

// *** verif/tb_read_wrap_training.sv ***
// Purpose: self-checking bench for read_wrap_training
// Assumes: array byte is address low byte xor a5
// Notes: random patterns, dummies and wrap starts, fixed seed
`timescale 1ns/1ns
`include "read_wrap_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_read_wrap_training;
  reg clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [7:0] pat, code;
  reg [22:0] st;
  integer seed = 32'hdbb2a8e8, badCount = 0, checked = 0, cyc = 0, i, k, n;
  wire [31:0] prdata;
  wire pready, pslverr, sclk, csn, dataOe;
  wire [7:0] dataOut, memData;
  wire [22:0] memAddr;
  assign memData = memAddr[7:0] ^ 8'ha5;
  initial forever #25 clk_sys = ~clk_sys;
  read_wrap_training i_read_wrap_training (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .csn(csn), .dataOut(dataOut),
    .dataOe(dataOe), .memAddr(memAddr), .memData(memData));
  host_model i_host_model (.sclk(sclk), .csn(csn), .dataOut(dataOut));
  // one apb transfer, request held until pready is seen
  task apb(input w, input [7:0] ix, input [31:0] d);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, ix, 2'b00, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task train(input [7:0] p, input sw, input integer nd);
    apb(1, `IDX_CMD, `CMD_TRAIN);
    i_host_model.frame(nd + `TRAIN_EXTRA + 16);
    for (k = 0; k < 16; k++) `CHK(i_host_model.cap[nd + 2 + k], {8{p[7 - k % 8]}} ^ {4'h0, ~sw, 3'h0})
  endtask
  function [7:0] wexp(input [7:0] c, input [22:0] s, input integer j);
    reg [22:0] m, a;
    m = c == `WRAP_64 ? 23'd63 : c == `WRAP_32 ? 23'd31 : c == `WRAP_16 ? 23'd15 : ~23'd0;
    a = (s & ~m) | ((s + j) & m);
    wexp = a[7:0] ^ 8'ha5;
  endfunction
  task finish_test;
    if (cyc >= 40000) badCount++;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc == 40000) finish_test;
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(0, `IDX_TRAIN, 0);
    `CHK(rd[7:0], `TRAIN_RST)
    apb(0, 8'h3c, 0);
    `CHK(err, 1'b1)
    apb(1, `IDX_DUMMY, 2);
    apb(0, `IDX_STAT, 0);
    `CHK(rd[31], 1'b1)
    apb(1, `IDX_DUMMY, 0);
    apb(0, `IDX_STAT, 0);
    `CHK(rd[31], 1'b0)
    train(`TRAIN_RST, 1'b1, 18);
    // each pass: new pattern and lane mode, then a read with wrap code ffh, feh, fdh, fch in turn
    for (i = 0; i < 8; i++) begin
      pat = 8'($random(seed));
      n = 3 + {$random(seed)} % 28;
      st = 23'($random(seed)) | 23'h30;
      code = 8'hff - 8'(i % 4);
      apb(1, `IDX_DUMMY, n);
      apb(1, `IDX_TRAIN, pat);
      apb(0, `IDX_TRAIN, 0);
      `CHK(rd[7:0], pat)
      apb(1, `IDX_SWSEL, {25'h0, i[0], 6'h3f});
      train(pat, i[0], n);
      apb(1, `IDX_WRAP, code);
      apb(1, `IDX_START, st);
      apb(1, `IDX_CMD, `CMD_READ);
      i_host_model.frame(n + 20);
      for (k = 0; k < 20; k++) `CHK(i_host_model.cap[n + k], wexp(code, st, k))
    end
    finish_test;
  end
endmodule // tb_read_wrap_training
bind read_wrap_training read_wrap_training_sva i_read_wrap_training_sva (.clk_sys(clk_sys),
  .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .sclk(sclk), .csn(csn), .dataOut(dataOut), .dataOe(dataOe));
